//--- inc/mse_pkg.sv
// Package: register map, error codes and sizes of the status/error block
package mse_pkg;
    // Database geometry
    localparam int DB_WORDS = 5000;
    localparam int MAX_CMDS = 100;
    localparam int STATUS_WORDS = 33;
    localparam logic [12:0] STATUS_BASE = 13'h1c20;
    // Printed register indices (byte address is four times the index)
    localparam logic [12:0] IDX_P2_RX_ERR = 13'h1c36;
    localparam logic [12:0] IDX_RD_XFER = 13'h1c37;
    localparam logic [12:0] IDX_WR_XFER = 13'h1c38;
    localparam logic [12:0] IDX_PARSE_UNUSED = 13'h1c39;
    localparam logic [12:0] IDX_EVT_REQ = 13'h1c3a;
    localparam logic [12:0] IDX_REQ_BLK = 13'h1c3b;
    localparam logic [12:0] IDX_BAD_BLK = 13'h1c3c;
    localparam logic [12:0] IDX_P1_NEW = 13'h1c3d;
    localparam logic [12:0] IDX_P1_PRIOR = 13'h1c3e;
    localparam logic [12:0] IDX_P2_NEW = 13'h1c3f;
    localparam logic [12:0] IDX_P2_PRIOR = 13'h1c40;
    // Configuration registers of our own, word indices
    localparam logic [12:0] IDX_ERR_BASE = 13'h1c41;
    localparam logic [12:0] IDX_CMD_TOTAL = 13'h1c42;
    localparam logic [12:0] IDX_APPLY = 13'h1c43;
    localparam logic [15:0] ERR_BASE_RST = 16'h0000;
    localparam logic [15:0] CMD_TOTAL_RST = 16'h0064;
    // Error codes, 16-bit two's complement
    localparam logic [15:0] EC_OK = 16'h0000;
    localparam logic [15:0] EC_NO_CTS = 16'hffff;
    localparam logic [15:0] EC_TX_TMO = 16'hfffe;
    localparam logic [15:0] EC_RSP_TMO = 16'hfff5;
    localparam logic [15:0] EC_BAD_ADDR = 16'h00fd;
    localparam logic [15:0] EC_BAD_FUNC = 16'h00fe;
    localparam logic [15:0] EC_BAD_CHK = 16'h00ff;
    localparam logic [15:0] EC_BAD_EN = 16'hffd7;
    localparam logic [15:0] EC_BAD_INT = 16'hffd6;
    localparam logic [15:0] EC_BAD_NODE = 16'hffd5;
    localparam logic [15:0] EC_ZERO_CNT = 16'hffd4;
    localparam logic [15:0] EC_BAD_FN = 16'hffd3;
    localparam logic [15:0] EC_BAD_SWAP = 16'hffd2;
    localparam logic [2:0] EXC_MIN = 3'h1;
    localparam logic [2:0] EXC_MAX = 3'h6;
    localparam logic [15:0] NODE_MAX = 16'h00ff;
    // Outcome kinds reported with each command completion
    typedef enum logic [3:0] {
        MSE_OC_OK, MSE_OC_EXC, MSE_OC_NO_CTS, MSE_OC_TX_TMO, MSE_OC_RSP_TMO,
        MSE_OC_BAD_ADDR, MSE_OC_BAD_FUNC, MSE_OC_BAD_CHK
    } mse_outcome_t;
    // Parse fault kinds, bit positions in parse_bits in order of priority
    typedef enum logic [2:0] {
        MSE_PF_EN, MSE_PF_INT, MSE_PF_NODE, MSE_PF_CNT, MSE_PF_FN, MSE_PF_SWAP
    } mse_parse_t;
    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;
endpackage

//--- verilog/mse_err_code.sv
// Module: maps a command outcome or parse fault to its 16-bit error code
`timescale 1ns/1ns
module mse_err_code
    import mse_pkg::*;
(
    input wire logic parse_fault,
    input wire logic [5:0] parse_bits,
    input wire logic [3:0] outcome,
    input wire logic [2:0] exc_code,
    output logic [15:0] code
);
    //--------------------------------------------------------------
    // Code selection
    //--------------------------------------------------------------
    // Parse faults report the first failing field in entry order
    always_comb begin
        code = EC_OK;
        if (parse_fault) begin
            if (parse_bits[MSE_PF_EN]) code = EC_BAD_EN;
            else if (parse_bits[MSE_PF_INT]) code = EC_BAD_INT;
            else if (parse_bits[MSE_PF_NODE]) code = EC_BAD_NODE;
            else if (parse_bits[MSE_PF_CNT]) code = EC_ZERO_CNT;
            else if (parse_bits[MSE_PF_FN]) code = EC_BAD_FN;
            else if (parse_bits[MSE_PF_SWAP]) code = EC_BAD_SWAP;
        end else begin
            unique case (outcome)
                MSE_OC_OK: code = EC_OK;
                MSE_OC_EXC: code = {13'h0000, exc_code};
                MSE_OC_NO_CTS: code = EC_NO_CTS;
                MSE_OC_TX_TMO: code = EC_TX_TMO;
                MSE_OC_RSP_TMO: code = EC_RSP_TMO;
                MSE_OC_BAD_ADDR: code = EC_BAD_ADDR;
                MSE_OC_BAD_FUNC: code = EC_BAD_FUNC;
                MSE_OC_BAD_CHK: code = EC_BAD_CHK;
                default: code = EC_OK;
            endcase
        end
    end
endmodule // mse_err_code

//--- verilog/mse_status_regs.sv
// Module: status counters, failure indices and command error table with AXI4-Lite access
// Contract
// - Count each message error received on port two.
// - Count each read block moved to the host.
// - Count each write block exchanged with the host.
// - Count each command event block accepted from the host.
// - Count each command block accepted from the host.
// - Count each erroneous host block recognised.
// - Per master port, hold index of newest failed command.
// - Per master port, hold index of the failure before it.
// - One error word per command, table at configured database base.
// - Table length equals configured command total, up to 100.
// - Slave exception responses store exception value 1 to 6.
// - Missing CTS before transmit records -1.
// - Request send timeout records -2.
// - No reply within response timeout records -11.
// - Reply slave address mismatch records 253.
// - Reply function code mismatch records 254.
// - Failed CRC or LRC check records 255.
// - Parse faults record -41, -42, -45, -46.
// - Node address outside 0..255 records -43.
// - Zero count, including blank entries, records -44.
// - Status forms a 33-word block; these words are its tail.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
module mse_status_regs
    import mse_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic p2_rx_error,
    input wire logic read_block_done,
    input wire logic write_block_done,
    input wire logic event_block_taken,
    input wire logic command_block_taken,
    input wire logic bad_block_seen,
    input wire logic cmd_done,
    input wire logic cmd_port,
    input wire logic [6:0] cmd_index,
    input wire logic [3:0] cmd_outcome,
    input wire logic [2:0] cmd_exc_code,
    input wire logic parse_fault,
    input wire logic [5:0] parse_bits,
    output logic [15:0] err_base,
    output logic [6:0] cmd_total
);
    //--------------------------------------------------------------
    // Storage
    //--------------------------------------------------------------
    logic [15:0] p2_rx_err_q, rd_xfer_q, wr_xfer_q, evt_req_q, req_blk_q, bad_blk_q;
    logic [15:0] p1_new_q, p1_prior_q, p2_new_q, p2_prior_q;
    logic [15:0] err_base_q, cmd_total_cfg_q;
    logic [6:0] cmd_total_q;
    logic [15:0] err_tab [0:MAX_CMDS-1];
    logic [15:0] code;
    logic [15:0] aw_q, wd_q;
    logic aw_have_q, w_have_q;
    // Declared early: configuration writes and the response both key off it
    logic bvalid_set;

    function automatic logic [15:0] bump(input logic [15:0] v);
        return v + 16'h0001; // Wraps naturally at 16 bits
    endfunction

    // Word index from a byte address
    function automatic logic [12:0] word_idx(input logic [15:0] a);
        return a[14:2];
    endfunction

    mse_err_code u_code (
        .parse_fault(parse_fault),
        .parse_bits(parse_bits),
        .outcome(cmd_outcome),
        .exc_code(cmd_exc_code),
        .code(code)
    );

    //--------------------------------------------------------------
    // Transfer counters
    //--------------------------------------------------------------
    // wrapping counters
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            p2_rx_err_q <= 16'h0000;
            rd_xfer_q <= 16'h0000;
            wr_xfer_q <= 16'h0000;
            evt_req_q <= 16'h0000;
            req_blk_q <= 16'h0000;
            bad_blk_q <= 16'h0000;
        end else begin
            if (p2_rx_error) p2_rx_err_q <= bump(p2_rx_err_q);
            if (read_block_done) rd_xfer_q <= bump(rd_xfer_q);
            if (write_block_done) wr_xfer_q <= bump(wr_xfer_q);
            if (event_block_taken) evt_req_q <= bump(evt_req_q);
            if (command_block_taken) req_blk_q <= bump(req_blk_q);
            if (bad_block_seen) bad_blk_q <= bump(bad_blk_q);
        end
    end

    //--------------------------------------------------------------
    // Failure indices
    //--------------------------------------------------------------
    logic fail;
    assign fail = cmd_done && (code != EC_OK);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            p1_new_q <= 16'h0000;
            p1_prior_q <= 16'h0000;
            p2_new_q <= 16'h0000;
            p2_prior_q <= 16'h0000;
        end else if (fail) begin
            if (!cmd_port) begin
                p1_prior_q <= p1_new_q;
                p1_new_q <= {9'h000, cmd_index};
            end else begin
                p2_prior_q <= p2_new_q;
                p2_new_q <= {9'h000, cmd_index};
            end
        end
    end

    //--------------------------------------------------------------
    // Command error table
    //--------------------------------------------------------------
    // one word per command
    always_ff @(posedge aclk) begin
        if (cmd_done && (cmd_index < cmd_total_q)) begin
            err_tab[cmd_index] <= code;
        end
    end

    //--------------------------------------------------------------
    // Configuration
    //--------------------------------------------------------------
    // total latched only at restart or apply strobe
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd_total_q <= 7'(MAX_CMDS);
        end else if (bvalid_set && word_idx(aw_q) == IDX_APPLY && wd_q[0]) begin
            cmd_total_q <= (cmd_total_cfg_q > 16'(MAX_CMDS)) ? 7'(MAX_CMDS)
                                                               : cmd_total_cfg_q[6:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            err_base_q <= ERR_BASE_RST;
            cmd_total_cfg_q <= CMD_TOTAL_RST;
        end else if (bvalid_set) begin
            if (word_idx(aw_q) == IDX_ERR_BASE) err_base_q <= wd_q;
            if (word_idx(aw_q) == IDX_CMD_TOTAL) cmd_total_cfg_q <= wd_q;
        end
    end
    assign err_base = err_base_q;
    assign cmd_total = cmd_total_q;

    //--------------------------------------------------------------
    // AXI4-Lite write channel
    //--------------------------------------------------------------
    assign bvalid_set = aw_have_q && w_have_q && !s_axi_bvalid;
    assign s_axi_awready = !aw_have_q;
    assign s_axi_wready = !w_have_q;

    // Address and data captured independently, answered when both held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_q <= 16'h0000;
            wd_q <= 16'h0000;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= AXI_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_have_q) begin
                aw_have_q <= 1'b1;
                aw_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_have_q) begin
                w_have_q <= 1'b1;
                wd_q <= {s_axi_wstrb[1] ? s_axi_wdata[15:8] : 8'h00,
                         s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00};
            end
            if (bvalid_set) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= is_cfg(aw_q) ? AXI_OKAY : AXI_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
            end
        end
    end

    function automatic logic is_cfg(input logic [15:0] a);
        return (word_idx(a) == IDX_ERR_BASE) || (word_idx(a) == IDX_CMD_TOTAL)
            || (word_idx(a) == IDX_APPLY);
    endfunction

    //--------------------------------------------------------------
    // AXI4-Lite read channel
    //--------------------------------------------------------------
    logic [12:0] ridx;
    logic [12:0] tab_off;
    logic [15:0] rword;
    logic rhit;
    assign s_axi_arready = !s_axi_rvalid;
    assign ridx = word_idx(s_axi_araddr);
    assign tab_off = ridx - err_base_q[12:0];

    always_comb begin
        rword = 16'h0000;
        rhit = 1'b1;
        unique case (ridx)
            IDX_P2_RX_ERR: rword = p2_rx_err_q;
            IDX_RD_XFER: rword = rd_xfer_q;
            IDX_WR_XFER: rword = wr_xfer_q;
            IDX_PARSE_UNUSED: rword = 16'h0000; // Reserved, reads zero
            IDX_EVT_REQ: rword = evt_req_q;
            IDX_REQ_BLK: rword = req_blk_q;
            IDX_BAD_BLK: rword = bad_blk_q;
            IDX_P1_NEW: rword = p1_new_q;
            IDX_P1_PRIOR: rword = p1_prior_q;
            IDX_P2_NEW: rword = p2_new_q;
            IDX_P2_PRIOR: rword = p2_prior_q;
            IDX_ERR_BASE: rword = err_base_q;
            IDX_CMD_TOTAL: rword = cmd_total_cfg_q;
            IDX_APPLY: rword = {9'h000, cmd_total_q};
            default: begin
                // Table window follows the configured base and live total
                if (ridx >= err_base_q[12:0] && tab_off < 13'(cmd_total_q)) begin
                    rword = err_tab[tab_off[6:0]];
                end else begin
                    rhit = 1'b0;
                end
            end
        endcase
    end

    // One-cycle read latency; rdata held until taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= AXI_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {16'h0000, rword};
            s_axi_rresp <= rhit ? AXI_OKAY : AXI_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    //--------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------
    AST_P2_COUNT: assert property (@(posedge aclk) disable iff (!aresetn)
        p2_rx_error |=> p2_rx_err_q == $past(p2_rx_err_q) + 16'h0001)
        else $error("port two error count did not step");
    AST_RD_COUNT: assert property (@(posedge aclk) disable iff (!aresetn)
        !read_block_done |=> $stable(rd_xfer_q))
        else $error("read count moved without a block");
    AST_WR_COUNT: assert property (@(posedge aclk) disable iff (!aresetn)
        write_block_done |=> wr_xfer_q == $past(wr_xfer_q) + 16'h0001)
        else $error("write count did not step");
    AST_EVT_COUNT: assert property (@(posedge aclk) disable iff (!aresetn)
        event_block_taken |=> evt_req_q == $past(evt_req_q) + 16'h0001)
        else $error("event count did not step");
    AST_REQ_COUNT: assert property (@(posedge aclk) disable iff (!aresetn)
        command_block_taken |=> req_blk_q == $past(req_blk_q) + 16'h0001)
        else $error("command block count did not step");
    AST_BAD_COUNT: assert property (@(posedge aclk) disable iff (!aresetn)
        bad_block_seen |=> bad_blk_q == $past(bad_blk_q) + 16'h0001)
        else $error("bad block count did not step");
    AST_P1_NEW: assert property (@(posedge aclk) disable iff (!aresetn)
        fail && !cmd_port |=> p1_new_q == {9'h000, $past(cmd_index)})
        else $error("port one newest index wrong");
    AST_P1_SHIFT: assert property (@(posedge aclk) disable iff (!aresetn)
        fail && !cmd_port |=> p1_prior_q == $past(p1_new_q))
        else $error("port one prior index not shifted");
    AST_P2_SHIFT: assert property (@(posedge aclk) disable iff (!aresetn)
        fail && cmd_port |=> p2_prior_q == $past(p2_new_q) && $stable(p1_new_q))
        else $error("port two prior index not shifted");
    AST_OK_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
        cmd_done && !parse_fault && cmd_outcome == MSE_OC_OK && cmd_index < cmd_total_q
        |=> err_tab[$past(cmd_index)] == EC_OK)
        else $error("success did not clear error word");
    AST_RSP_TMO: assert property (@(posedge aclk) disable iff (!aresetn)
        !parse_fault && cmd_outcome == MSE_OC_RSP_TMO |-> code == EC_RSP_TMO)
        else $error("response timeout code wrong");
    AST_BLANK: assert property (@(posedge aclk) disable iff (!aresetn)
        parse_fault && parse_bits[3:0] == 4'h8 |-> code == EC_ZERO_CNT)
        else $error("zero count code wrong");
    AST_RD_STEP: assert property (@(posedge aclk) disable iff (!aresetn)
        read_block_done |=> rd_xfer_q == $past(rd_xfer_q) + 16'h0001)
        else $error("read count did not step");
    AST_P2_NEW: assert property (@(posedge aclk) disable iff (!aresetn)
        fail && cmd_port |=> p2_new_q == {9'h000, $past(cmd_index)})
        else $error("port two newest index wrong");
    AST_NO_CTS: assert property (@(posedge aclk) disable iff (!aresetn)
        !parse_fault && cmd_outcome == MSE_OC_NO_CTS |-> code == EC_NO_CTS)
        else $error("missing CTS code wrong");
    AST_BAD_CHK: assert property (@(posedge aclk) disable iff (!aresetn)
        !parse_fault && cmd_outcome == MSE_OC_BAD_CHK |-> code == EC_BAD_CHK)
        else $error("check failure code wrong");
    AST_NODE: assert property (@(posedge aclk) disable iff (!aresetn)
        parse_fault && parse_bits[2:0] == 3'h4 |-> code == EC_BAD_NODE)
        else $error("node range code wrong");
    AST_TOTAL_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        !bvalid_set |=> $stable(cmd_total_q))
        else $error("live command total moved without a write");
endmodule // mse_status_regs

//--- test/mse_cmd_engine_model.sv
// Model of the command engine and serial slaves that report command results
`timescale 1ns/1ns
module mse_cmd_engine_model
    import mse_pkg::*;
(
    input wire logic aclk,
    output logic cmd_done,
    output logic cmd_port,
    output logic [6:0] cmd_index,
    output logic [3:0] cmd_outcome,
    output logic [2:0] cmd_exc_code,
    output logic parse_fault,
    output logic [5:0] parse_bits
);
    // Quiet lines at time zero
    initial begin
        cmd_done = 1'b0;
        {cmd_port, cmd_index, cmd_outcome, cmd_exc_code, parse_fault, parse_bits} = 22'h0;
    end
    // One result pulse; released lines then show the inverse, never the old value
    task automatic finish(logic p, logic [6:0] idx, logic [3:0] oc, logic [2:0] exc,
                          logic pf, logic [5:0] pb);
        @(posedge aclk);
        cmd_done <= 1'b1;
        {cmd_port, cmd_index, cmd_outcome, cmd_exc_code, parse_fault, parse_bits} <=
            {p, idx, oc, exc, pf, pb};
        @(posedge aclk);
        cmd_done <= 1'b0;
        {cmd_port, cmd_index, cmd_outcome, cmd_exc_code, parse_fault, parse_bits} <=
            ~{p, idx, oc, exc, pf, pb};
    endtask
endmodule // mse_cmd_engine_model

//--- test/tb_modbus_master_status_errors.sv
// Testbench: AXI4-Lite master, host event pulses and command results
`timescale 1ns/1ns
module tb_modbus_master_status_errors;
    import mse_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [15:0] awaddr = 16'h0, araddr = 16'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, cmd_done, cmd_port, parse_fault;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [5:0] ev_q = 6'h0;
    logic [6:0] cmd_index, cmd_total;
    logic [3:0] cmd_outcome;
    logic [2:0] cmd_exc_code;
    logic [5:0] parse_bits;
    logic [15:0] err_base;
    int n_mismatch = 0;
    int n_compared = 0;
    logic [31:0] seed = 32'h36b1;
    logic [33:0] rq[$];
    logic [1:0] wq[$];
    logic [15:0] cnt[6], newest[2], prior[2];
    logic [12:0] base_e = 13'h0;
    localparam logic [12:0] CIDX[6] = '{IDX_P2_RX_ERR, IDX_RD_XFER, IDX_WR_XFER,
                                        IDX_EVT_REQ, IDX_REQ_BLK, IDX_BAD_BLK};
    localparam logic [15:0] PC[6] = '{EC_BAD_EN, EC_BAD_INT, EC_BAD_NODE,
                                      EC_ZERO_CNT, EC_BAD_FN, EC_BAD_SWAP};
    localparam logic [15:0] OC[8] = '{EC_OK, 16'h0, EC_NO_CTS, EC_TX_TMO, EC_RSP_TMO,
                                      EC_BAD_ADDR, EC_BAD_FUNC, EC_BAD_CHK};

    always #10 aclk = ~aclk;

    mse_status_regs i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .p2_rx_error(ev_q[0]), .read_block_done(ev_q[1]),
        .write_block_done(ev_q[2]), .event_block_taken(ev_q[3]),
        .command_block_taken(ev_q[4]), .bad_block_seen(ev_q[5]), .cmd_done(cmd_done),
        .cmd_port(cmd_port), .cmd_index(cmd_index), .cmd_outcome(cmd_outcome),
        .cmd_exc_code(cmd_exc_code), .parse_fault(parse_fault), .parse_bits(parse_bits),
        .err_base(err_base), .cmd_total(cmd_total));
    mse_cmd_engine_model i_eng (.aclk(aclk), .cmd_done(cmd_done), .cmd_port(cmd_port),
        .cmd_index(cmd_index), .cmd_outcome(cmd_outcome), .cmd_exc_code(cmd_exc_code),
        .parse_fault(parse_fault), .parse_bits(parse_bits));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Write; both channels offered together, each released once taken
    task automatic wr(logic [12:0] idx, logic [15:0] d, logic [1:0] resp);
        int n;
        logic a, w;
        wq.push_back(resp);
        @(posedge aclk);
        {awaddr, wdata} <= {1'b0, idx, 2'b00, 16'h0, d};
        {awvalid, wvalid, bready} <= 3'b111;
        {a, w, n} = 0;
        while (!(a && w) && n < 40) begin
            @(posedge aclk);
            n++;
            if (!a && awready === 1'b1) begin a = 1'b1; awvalid <= 1'b0; end
            if (!w && wready === 1'b1) begin w = 1'b1; wvalid <= 1'b0; end
        end
        do begin @(posedge aclk); n++; end while (bvalid !== 1'b1 && n < 40);
        bready <= 1'b0;
        if (n >= 40) check("write timeout", 32'h1, 32'h0);
    endtask
    // Read; the expected word is noted before the request goes out
    task automatic rd(logic [12:0] idx, logic [15:0] exp, logic [1:0] resp);
        int n;
        rq.push_back({resp, 16'h0, exp});
        @(posedge aclk);
        araddr <= {1'b0, idx, 2'b00};
        {arvalid, rready} <= 2'b11;
        n = 0;
        do begin @(posedge aclk); n++; end while (arready !== 1'b1 && n < 40);
        arvalid <= 1'b0;
        do begin @(posedge aclk); n++; end while (rvalid !== 1'b1 && n < 40);
        rready <= 1'b0;
        if (n >= 40) check("read timeout", 32'h1, 32'h0);
    endtask
    // Hold one event line high for k cycles; each high cycle counts once
    task automatic pulse(int b, int k);
        @(posedge aclk);
        ev_q[b] <= 1'b1;
        repeat (k) @(posedge aclk);
        ev_q[b] <= 1'b0;
        cnt[b] = cnt[b] + k[15:0];
        rd(CIDX[b], cnt[b], AXI_OKAY);
    endtask
    // One command result, then its table word and the port's two failure indices
    task automatic run_cmd(logic p, logic [6:0] idx, logic [3:0] oc, logic [2:0] exc,
                           logic pf, logic [5:0] pb);
        logic [15:0] c;
        c = (oc == 4'h1) ? {13'h0, exc} : OC[oc[2:0]];
        if (pf) for (int i = 5; i >= 0; i--) if (pb[i]) c = PC[i];
        i_eng.finish(p, idx, oc, exc, pf, pb);
        if (c !== EC_OK) begin prior[p] = newest[p]; newest[p] = {9'h0, idx}; end
        rd(base_e + 13'(idx), c, AXI_OKAY);
        rd(p ? IDX_P2_NEW : IDX_P1_NEW, newest[p], AXI_OKAY);
        rd(p ? IDX_P2_PRIOR : IDX_P1_PRIOR, prior[p], AXI_OKAY);
    endtask

    // Result watcher: oldest note against each response that appears
    always @(posedge aclk) begin
        if (rvalid === 1'b1 && rready === 1'b1 && rq.size() > 0) begin
            check("rdata", rdata, rq[0][31:0]);
            check("rresp", {30'h0, rresp}, {30'h0, rq[0][33:32]});
            void'(rq.pop_front());
        end
        if (bvalid === 1'b1 && bready === 1'b1 && wq.size() > 0) begin
            check("bresp", {30'h0, bresp}, {30'h0, wq[0]});
            void'(wq.pop_front());
        end
    end

    // Watchdog at 90k cycles, above the roughly 66k-cycle run
    initial begin
        #1800000;
        n_mismatch++;
        conclude();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin cnt[i] = 16'h0; rd(CIDX[i], 16'h0, AXI_OKAY); end
        for (int p = 0; p < 2; p++) begin newest[p] = 16'h0; prior[p] = 16'h0; end
        rd(IDX_P1_NEW, 16'h0, AXI_OKAY);
        rd(IDX_P2_PRIOR, 16'h0, AXI_OKAY);
        rd(IDX_CMD_TOTAL, CMD_TOTAL_RST, AXI_OKAY);
        rd(IDX_ERR_BASE, ERR_BASE_RST, AXI_OKAY);
        rd(13'h1000, 16'h0, AXI_SLVERR);
        wr(IDX_RD_XFER, 16'h1234, AXI_SLVERR);
        rd(IDX_RD_XFER, 16'h0, AXI_OKAY);
        $display("test reset done");
        for (int r = 0; r < 2; r++)
            for (int i = 0; i < 6; i++) pulse(i, int'(rnd() % 7) + 1);
        $display("test counters done");
        // Every outcome and every exception value, random port and index
        for (int k = 0; k < 14; k++)
            run_cmd(1'(rnd()), 7'(rnd() % 100), (k < 8) ? 4'(k) : 4'h1,
                    (k < 8) ? 3'h1 : 3'(k - 7), 1'b0, 6'h0);
        // Each parse fault, with random higher bits to show the lowest one wins
        for (int b = 0; b < 6; b++)
            run_cmd(1'(rnd()), 7'(rnd() % 100), 4'h0, 3'h1, 1'b1,
                    6'((rnd() << b) | (1 << b)));
        $display("test commands done");
        wr(IDX_ERR_BASE, 16'h00c8, AXI_OKAY);
        check("err_base", {16'h0, err_base}, 32'h00c8);
        base_e = 13'h00c8;
        run_cmd(1'b0, 7'd3, 4'h5, 3'h1, 1'b0, 6'h0);
        wr(IDX_CMD_TOTAL, 16'h0005, AXI_OKAY);
        rd(IDX_APPLY, 16'h0064, AXI_OKAY);
        check("cmd_total", {25'h0, cmd_total}, 32'h64);
        // Apply stands in for the power cycle after a new total
        wr(IDX_APPLY, 16'h0001, AXI_OKAY);
        rd(IDX_APPLY, 16'h0005, AXI_OKAY);
        check("cmd_total", {25'h0, cmd_total}, 32'h5);
        rd(13'h00cf, 16'h0, AXI_SLVERR);
        run_cmd(1'b1, 7'd4, 4'h6, 3'h1, 1'b0, 6'h0);
        $display("test config done");
        pulse(0, 65536);
        $display("test wrap done");
        repeat (4) @(posedge aclk);
        conclude();
    end
endmodule // tb_modbus_master_status_errors
